// File: logic/dws_pkg.sv
// Purpose: shared constants and types for the dram wait state sequencer
// Assumes: apb slave with 32-bit data, one word per register
// Notes: field positions refer to dram_timing_config
package dws_pkg;
   // register byte offsets
   localparam logic [11:0] DWS_CFG_OFFSET = 12'h000;
   localparam logic [11:0] DWS_STATUS_OFFSET = 12'h004;
   // dram_timing_config layout and reset value
   localparam logic [15:0] DWS_CFG_RESET = 16'hffff;
   localparam int DWS_RD_FIRST_LSB = 0;
   localparam int DWS_RD_BEAT_LSB = 2;
   localparam int DWS_WR_FIRST_LSB = 4;
   localparam int DWS_WR_BEAT_LSB = 6;
   localparam int DWS_PRECHARGE_BIT = 8;
   localparam int DWS_REFRESH_PULSE_BIT = 9;
   localparam int DWS_ADS_DELAY_BIT = 10;
   localparam int DWS_CFG_WIDTH = 16;
   localparam int DWS_STATE_COUNT = 13;
   // status word layout
   localparam int DWS_STAT_PEND_BIT = 16;
   localparam int DWS_STAT_PEND_WR_BIT = 17;

   // codes form a gray sequence in declaration order, idle through precharge
   typedef enum logic [3:0] {
      DWS_IDLE = 4'h0,
      DWS_RFSH1 = 4'h1,
      DWS_RFSH2 = 4'h3,
      DWS_RFSH3 = 4'h2,
      DWS_RFSH4 = 4'h6,
      DWS_FIRST = 4'h7,
      DWS_RD2 = 4'h5,
      DWS_RD3 = 4'h4,
      DWS_RD4 = 4'hc,
      DWS_WR2 = 4'hd,
      DWS_WR3 = 4'hf,
      DWS_WR4 = 4'he,
      DWS_PRECHG = 4'ha
   } dws_state_type;

   // one indicator per state, bit order matches the status register
   typedef struct packed {
      logic precharge;
      logic [2:0] write_data_states;
      logic [2:0] read_data_states;
      logic first_data_state;
      logic [3:0] refresh_states;
      logic idle_state;
   } dws_ind_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } dws_apb_rsp_type;

   typedef struct packed {
      dws_state_type state;
      logic [DWS_CFG_WIDTH-1:0] cfg;
      logic pend;
      logic pend_wr;
      logic req_dly;
      dws_ind_type ind;
      dws_apb_rsp_type apb;
   } dws_regs_type;
endpackage

// File: logic/dws_sequencer.sv
// Purpose: dram controller state machine with configurable wait state profile
// Assumes: bus inputs synchronous to pclk; refresh_request held until refresh starts
// Notes: registers reached over apb; all outputs registered
// Function
// R1: after reset dram_timing_config holds 0xffff, the slowest timing.
// R2: the first profile element sets the waits between address cycle and first data.
// R3: later profile elements set one common wait count between successive data beats.
// R4: an access is one address cycle, first waits, one cycle per word, beat waits, recovery.
// R5: the bus master may append recovery cycles after the last beat.
// R6: a read picks its first wait path from read_first_waits: 11 longest, 10 shorter, 0x shortest.
// R7: a continuing read picks its beat path from read_beat_waits: 1x, 01, 00 in falling length.
// R8: a write picks its first wait path from write_first_waits: 11, 10, 0x in falling length.
// R9: a continuing write picks its beat path from write_beat_waits: 1x longer, 0x shorter.
// R10: on the last beat with precharge_select set the exit adds a precharge cycle.
// R11: on the last beat with precharge_select clear the exit goes straight to idle.
// R12: each state drives its own indicator output.
// R13: a refresh request beats an access request arriving in the same cycle.
// R14: refresh_pulse_select clear skips the third refresh state.
// R15: precharge_select gives one idle cycle of precharge when clear and two when set.
// R16: addr_strobe_n low with the top two address bits 00 starts a dram request.
// R17: after the last refresh or precharge state the machine idles and serves a pending access.
`timescale 1ns/1ps
module dws_sequencer
   import dws_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic addr_strobe_n,
   input wire logic [1:0] addr_top,
   input wire logic write_not_read,
   input wire logic burst_last_n,
   input wire logic refresh_request,
   output dws_ind_type state_ind
);
   dws_regs_type r_r;
   dws_regs_type r_nxt;

   function automatic dws_ind_type decode(input dws_state_type s);
      dws_ind_type d;
      d = '0;
      unique case (s)
         DWS_IDLE:
         begin
            d.idle_state = 1'b1;
         end
         DWS_RFSH1:
         begin
            d.refresh_states[0] = 1'b1;
         end
         DWS_RFSH2:
         begin
            d.refresh_states[1] = 1'b1;
         end
         DWS_RFSH3:
         begin
            d.refresh_states[2] = 1'b1;
         end
         DWS_RFSH4:
         begin
            d.refresh_states[3] = 1'b1;
         end
         DWS_FIRST:
         begin
            d.first_data_state = 1'b1;
         end
         DWS_RD2:
         begin
            d.read_data_states[0] = 1'b1;
         end
         DWS_RD3:
         begin
            d.read_data_states[1] = 1'b1;
         end
         DWS_RD4:
         begin
            d.read_data_states[2] = 1'b1;
         end
         DWS_WR2:
         begin
            d.write_data_states[0] = 1'b1;
         end
         DWS_WR3:
         begin
            d.write_data_states[1] = 1'b1;
         end
         DWS_WR4:
         begin
            d.write_data_states[2] = 1'b1;
         end
         DWS_PRECHG:
         begin
            d.precharge = 1'b1;
         end
         default:
         begin
            d.idle_state = 1'b1;
         end
      endcase
      return d;
   endfunction

   always_comb
   begin
      logic req_raw;
      logic req_now;
      logic req_wr;
      logic any_req;
      logic take;
      logic last;
      logic [1:0] rd_first;
      logic [1:0] rd_beat;
      logic [1:0] wr_first;
      logic [1:0] wr_beat;
      logic apb_hit;
      logic is_cfg;
      logic is_stat;
      logic [31:0] rdata;
      req_raw = 1'b0;
      req_now = 1'b0;
      req_wr = 1'b0;
      any_req = 1'b0;
      take = 1'b0;
      last = 1'b0;
      rd_first = '0;
      rd_beat = '0;
      wr_first = '0;
      wr_beat = '0;
      apb_hit = 1'b0;
      is_cfg = 1'b0;
      is_stat = 1'b0;
      rdata = '0;
      r_nxt = r_r;

      rd_first = r_r.cfg[DWS_RD_FIRST_LSB +: 2];
      rd_beat = r_r.cfg[DWS_RD_BEAT_LSB +: 2];
      wr_first = r_r.cfg[DWS_WR_FIRST_LSB +: 2];
      wr_beat = r_r.cfg[DWS_WR_BEAT_LSB +: 2];
      last = ~burst_last_n;

      // request seen now or one cycle late, so slow address decode can settle
      req_raw = ~addr_strobe_n && (addr_top == 2'b00); // [R16]
      r_nxt.req_dly = req_raw;
      req_now = r_r.cfg[DWS_ADS_DELAY_BIT] ? r_r.req_dly : req_raw; // [R16]
      // the delayed path relies on the master holding its direction for that cycle
      req_wr = req_now ? write_not_read : r_r.pend_wr;
      any_req = r_r.pend | req_now;

      unique case (r_r.state)
         DWS_IDLE:
         begin
            if (refresh_request)
            begin
               r_nxt.state = DWS_RFSH1; // [R13]
            end
            else if (any_req)
            begin
               take = 1'b1; // [R17]
               r_nxt.state = DWS_FIRST; // [R4]
            end
         end
         DWS_RFSH1:
         begin
            r_nxt.state = DWS_RFSH2;
         end
         DWS_RFSH2:
         begin
            if (r_r.cfg[DWS_REFRESH_PULSE_BIT])
            begin
               r_nxt.state = DWS_RFSH3; // [R14]
            end
            else
            begin
               r_nxt.state = DWS_RFSH4; // [R14]
            end
         end
         DWS_RFSH3:
         begin
            r_nxt.state = DWS_RFSH4;
         end
         DWS_RFSH4:
         begin
            r_nxt.state = DWS_IDLE; // [R17]
         end
         DWS_FIRST:
         begin
            // first wait cycle is this state; later states add the longer paths
            if (r_r.pend_wr)
            begin
               unique case (wr_first) // [R2] [R8]
                  2'b11: r_nxt.state = DWS_WR2;
                  2'b10: r_nxt.state = DWS_WR3;
                  2'b01, 2'b00: r_nxt.state = DWS_WR4;
               endcase
            end
            else
            begin
               unique case (rd_first) // [R2] [R6]
                  2'b11: r_nxt.state = DWS_RD2;
                  2'b10: r_nxt.state = DWS_RD3;
                  2'b01, 2'b00: r_nxt.state = DWS_RD4;
               endcase
            end
         end
         DWS_RD2:
         begin
            r_nxt.state = DWS_RD3;
         end
         DWS_RD3:
         begin
            r_nxt.state = DWS_RD4;
         end
         DWS_RD4:
         begin
            if (last)
            begin
               if (r_r.cfg[DWS_PRECHARGE_BIT])
               begin
                  r_nxt.state = DWS_PRECHG; // [R10]
               end
               else
               begin
                  r_nxt.state = DWS_IDLE; // [R11]
               end
            end
            else if (rd_beat[1])
            begin
               r_nxt.state = DWS_RD2; // [R3] [R7]
            end
            else if (rd_beat[0])
            begin
               r_nxt.state = DWS_RD3; // [R3] [R7]
            end
            else
            begin
               r_nxt.state = DWS_RD4; // [R3] [R7]
            end
         end
         DWS_WR2:
         begin
            r_nxt.state = DWS_WR3;
         end
         DWS_WR3:
         begin
            r_nxt.state = DWS_WR4;
         end
         DWS_WR4:
         begin
            if (last)
            begin
               if (r_r.cfg[DWS_PRECHARGE_BIT])
               begin
                  r_nxt.state = DWS_PRECHG; // [R10]
               end
               else
               begin
                  r_nxt.state = DWS_IDLE; // [R11]
               end
            end
            else if (wr_beat[1])
            begin
               r_nxt.state = DWS_WR2; // [R3] [R9]
            end
            else
            begin
               r_nxt.state = DWS_WR3; // [R3] [R9]
            end
         end
         // idle after this gives the second precharge cycle
         DWS_PRECHG:
         begin
            r_nxt.state = DWS_IDLE; // [R15] [R17]
         end
         default:
         begin
            r_nxt.state = DWS_IDLE;
         end
      endcase

      // a request arriving during refresh or a burst waits here
      if (take)
      begin
         r_nxt.pend = 1'b0;
         r_nxt.pend_wr = req_wr;
      end
      else
      begin
         r_nxt.pend = any_req; // [R13] [R17]
         r_nxt.pend_wr = req_wr;
      end

      r_nxt.ind = decode(r_nxt.state); // [R12]

      // apb: one wait cycle in the access phase, answer from a flop
      is_cfg = paddr == DWS_CFG_OFFSET;
      is_stat = paddr == DWS_STATUS_OFFSET;
      apb_hit = psel && penable && r_r.apb.pready;
      if (apb_hit && pwrite && is_cfg)
      begin
         if (pstrb[0])
         begin
            r_nxt.cfg[7:0] = pwdata[7:0];
         end
         if (pstrb[1])
         begin
            r_nxt.cfg[15:8] = pwdata[15:8];
         end
      end
      if (is_cfg)
      begin
         rdata = {16'h0000, r_r.cfg};
      end
      else if (is_stat)
      begin
         rdata = 32'h0000_0000;
         rdata[DWS_STATE_COUNT-1:0] = r_r.ind;
         rdata[DWS_STAT_PEND_BIT] = r_r.pend;
         rdata[DWS_STAT_PEND_WR_BIT] = r_r.pend_wr;
      end
      r_nxt.apb.pready = psel && penable && !r_r.apb.pready;
      r_nxt.apb.prdata = (psel && penable && !r_r.apb.pready && !pwrite) ? rdata : 32'h0000_0000;
      // status is read only; writes there and any unmapped access answer with an error
      r_nxt.apb.pslverr = psel && penable && !r_r.apb.pready && !(is_cfg || (is_stat && !pwrite));
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         r_r <= '{state: DWS_IDLE, cfg: DWS_CFG_RESET, pend: 1'b0, pend_wr: 1'b0,
                  req_dly: 1'b0, ind: 13'h0001, apb: '0}; // [R1]
      end
      else if (clk_en)
      begin
         r_r <= r_nxt;
      end
   end

   assign prdata = r_r.apb.prdata;
   assign pready = r_r.apb.pready;
   assign pslverr = r_r.apb.pslverr;
   assign state_ind = r_r.ind;
endmodule // dws_sequencer

// File: tb/dws_monitor.sv
// Purpose: port checker for dws_sequencer
// Assumes: clk_en held high
// Notes: cfg is not visible here, so only paths valid for every cfg are checked
`timescale 1ns/1ps
module dws_monitor
   import dws_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic burst_last_n,
   input wire logic refresh_request,
   input wire dws_ind_type state_ind
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic [12:0] s = state_ind;
   chk_one_hot: assert property ($onehot(s))
      else $error("state indicators not one-hot");
   chk_refresh_wins: assert property (s[0] && refresh_request |=> s[1])
      else $error("refresh not taken from idle");
   chk_refresh_walk: assert property (s[1] |=> s[2] ##1 (s[3] || s[4]))
      else $error("refresh walk broken");
   chk_refresh_end: assert property (s[4] |=> s[0])
      else $error("refresh did not end in idle");
   chk_first_out: assert property (s[5] |=> |s[11:6])
      else $error("first state left wrongly");
   chk_read_wait: assert property (s[6] |=> s[7] ##1 s[8])
      else $error("read wait path broken");
   chk_write_wait: assert property (s[9] |=> s[10] ##1 s[11])
      else $error("write wait path broken");
   chk_beat_more: assert property (s[8] && burst_last_n |=> |s[8:6])
      else $error("read burst ended early");
   chk_last_exit: assert property ((s[8] || s[11]) && !burst_last_n |=> s[0] || s[12])
      else $error("last beat exit wrong");
   chk_prechg_idle: assert property (s[12] |=> s[0])
      else $error("precharge not one cycle");
   chk_apb_answer: assert property (pready |-> psel && penable && $past(penable) ##1 !pready)
      else $error("apb answer timing wrong");
   cover property (s[3]);
   cover property (s[12]);
   cover property (s[7] ##1 s[8]);
endmodule // dws_monitor
bind dws_sequencer dws_monitor dws_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pready(pready), .burst_last_n(burst_last_n),
   .refresh_request(refresh_request), .state_ind(state_ind));

// File: tb/dws_bus_master.sv
// Purpose: processor bus master issuing dram bursts
// Assumes: start only while the sequencer idles
// Notes: addr_top toggles outside a strobe and shows 00 every other cycle after the first burst, so decodes that ignore the strobe show up
`timescale 1ns/1ps
module dws_bus_master
   import dws_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic wr,
   input wire logic [2:0] nwords,
   input wire dws_ind_type state_ind,
   output logic addr_strobe_n,
   output logic [1:0] addr_top,
   output logic write_not_read,
   output logic burst_last_n
);
   logic [2:0] left_r;
   wire logic beat = state_ind.read_data_states[2] | state_ind.write_data_states[2];
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         left_r <= 3'h0;
         addr_strobe_n <= 1'b1;
         addr_top <= 2'h1;
         write_not_read <= 1'b0;
         burst_last_n <= 1'b1;
      end
      else
      begin
         addr_strobe_n <= !start;
         addr_top <= start ? 2'h0 : ~addr_top;
         if (start)
         begin
            left_r <= nwords;
            write_not_read <= wr;
            burst_last_n <= (nwords != 3'h1);
         end
         // recovery: bench waits for idle before the next start
         else if (beat && left_r != 3'h0)
         begin
            left_r <= left_r - 3'h1;
            burst_last_n <= (left_r != 3'h2);
         end
      end
endmodule // dws_bus_master

// File: tb/test_dws_sequencer.sv
// Purpose: self-checking bench for dws_sequencer
// Assumes: clk_en high, apb answers after one wait
// Notes: a burst is measured as its span of non-idle cycles
`timescale 1ns/1ps
module test_dws_sequencer
   import dws_pkg::*;
;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, asn, wnr, bln;
   logic [1:0] atop;
   logic rreq = 1'b0, start = 1'b0, wr = 1'b0;
   logic [2:0] nw = 3'h1;
   dws_ind_type ind;
   int n_mismatch = 0, n_compared = 0;
   initial forever #4 pclk = ~pclk;
   always @(posedge pclk) if (ind.refresh_states[1]) rreq <= 1'b0;
   dws_sequencer dws_sequencer_i (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h3),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .addr_strobe_n(asn), .addr_top(atop),
      .write_not_read(wnr), .burst_last_n(bln), .refresh_request(rreq), .state_ind(ind));
   dws_bus_master dws_bus_master_i (.pclk(pclk), .presetn(presetn), .start(start), .wr(wr),
      .nwords(nw), .state_ind(ind), .addr_strobe_n(asn), .addr_top(atop),
      .write_not_read(wnr), .burst_last_n(bln));
   task results;
      if (n_mismatch == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %s exp %h got %h", what, exp, got);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
      output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no cycle limit here: a missing answer is left to the watchdog
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task set_cfg(input logic [15:0] c);
      logic [31:0] q;
      logic e;
      apb(1'b1, DWS_CFG_OFFSET, {16'h0, c}, q, e);
      cmp("cfg write err", 32'h0, {31'h0, e});
      apb(1'b0, DWS_CFG_OFFSET, 32'h0, q, e);
      cmp("cfg readback", {16'h0, c}, q);
   endtask
   task span(output int n, output logic [12:0] f);
      n = 0;
      for (int k = 0; k < 40 && ind.idle_state; k++)
         @(posedge pclk);
      f = ind;
      while (!ind.idle_state && n < 40)
      begin
         @(posedge pclk);
         n++;
      end
   endtask
   task burst(input logic w, input logic [2:0] n, input int exp, input logic [12:0] ef = 13'h020,
      input logic rq = 1'b0);
      int got;
      logic [12:0] f;
      wr <= w;
      nw <= n;
      start <= 1'b1;
      @(posedge pclk);
      start <= 1'b0;
      // refresh raised so that it meets the strobe at the same sequencer edge
      if (rq)
      begin
         rreq <= 1'b1;
      end
      span(got, f);
      cmp("first state", ef, f);
      cmp("busy cycles", exp, got);
   endtask
   task t_reset;
      logic [31:0] q;
      logic e;
      apb(1'b0, DWS_CFG_OFFSET, 32'h0, q, e);
      cmp("cfg reset", 32'h0000ffff, q);
      apb(1'b0, DWS_STATUS_OFFSET, 32'h0, q, e);
      cmp("status idle", 32'h1, q);
      apb(1'b1, DWS_STATUS_OFFSET, 32'h0, q, e);
      cmp("ro write err", 32'h1, {31'h0, e});
      apb(1'b0, 12'h008, 32'h0, q, e);
      cmp("unmapped read", 32'h0, q);
   endtask
   task t_prechg;
      burst(1'b0, 3'h2, 8);
      burst(1'b1, 3'h2, 8);
      set_cfg(16'h0000);
      burst(1'b0, 3'h2, 3);
   endtask
   task t_read;
      // first waits 11, 10, 01 and beat waits 11, 01, 00
      for (int i = 0; i < 3; i++)
         for (int j = 0; j < 3; j++)
         begin
            set_cfg({12'h0, 2'(3 >> j), 2'(3 - i)});
            burst(1'b0, (i == j) ? 3'h1 : 3'h3, (i == j) ? 4 - i : 6 - i + 2 * (2 - j));
         end
   endtask
   task t_write;
      // first waits 11, 10, 00
      for (int i = 0; i < 3; i++)
         for (int j = 0; j < 2; j++)
         begin
            set_cfg({8'h0, j[0] ? 2'h0 : 2'h2, (i == 2) ? 2'h0 : 2'(3 - i), 4'h0});
            burst(1'b1, 3'h4, 7 - i + 3 * (2 - j));
         end
   endtask
   task t_refresh;
      int n;
      logic [12:0] f;
      for (int p = 0; p < 2; p++)
      begin
         set_cfg({6'h0, p[0], 9'h0});
         burst(1'b0, 3'h1, 3 + p, 13'h002, 1'b1);
         span(n, f);
         cmp("pending access", 2, n);
      end
   endtask
   task t_again;
      logic [31:0] q;
      logic e;
      // a reset in mid-run must undo the last programming
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, DWS_CFG_OFFSET, 32'h0, q, e);
      cmp("cfg after reset", 32'h0000ffff, q);
      burst(1'b1, 3'h2, 8);
   endtask
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_prechg;
      t_read;
      t_write;
      t_refresh;
      t_again;
      results;
   end
   initial
   begin
      #20000;
      n_mismatch++;
      results;
   end
endmodule // test_dws_sequencer
